// ---- common/tp_consts.svh ----
`ifndef TP_CONSTS_SVH
`define TP_CONSTS_SVH
// Register indices; the byte address is four times the index.
`define TP_IDX_TIMER7_CONTROL   14'h1050
`define TP_IDX_T7DAT  14'h1051
`define TP_IDX_TIMER8_CONTROL   14'h1052
`define TP_IDX_PCR1   14'h1053
`define TP_IDX_PCR2   14'h1054
`define TP_IDX_PCR3   14'h1055
`define TP_IDX_ISR    14'h1056
`define TP_IDX_MSK    14'h1057
`define TP_IDX_PERL   14'h1058
`define TP_IDX_PERH   14'h1059
`define TP_IDX_DAL    14'h105a
`define TP_IDX_DAH    14'h105b
`define TP_IDX_DBL    14'h105c
`define TP_IDX_DBH    14'h105d
`define TP_IDX_DCL    14'h105e
`define TP_IDX_DCH    14'h105f
`define TP_IDX_DLYA   14'h1060
`define TP_IDX_DLYB   14'h1061
`define TP_IDX_DLYC   14'h1062
`define TP_IDX_TIMER8_COMPARE_VALUE   14'h1063
`define TP_IDX_T8CAP  14'h1064
`define TP_IDX_TIMER8_COUNT_VALUE  14'h1065
// Reset values that are not zero.
`define TP_RST_TIMER7_COMPARE_VALUE   8'hff
`define TP_RST_TIMER8_COMPARE_VALUE   8'hff
`define TP_RST_PER    10'h0ff
`define TP_RST_DUTY   10'h07f
// First timer control fields.
`define TP_T7_EN      7
`define TP_T7_IE      6
`define TP_T7_MS      5
`define TP_T7_CK_HI   4
`define TP_T7_CK_LO   2
`define TP_T7_CN      1
`define TP_T7_ST      0
// Second timer control fields.
`define TP_T8_MS      6
`define TP_T8_CN      5
`define TP_T8_ST      4
`define TP_T8_CK_HI   3
// PWM control one fields.
`define TP_P1_PWMEN   7
`define TP_P1_EXT_SYNC_ENABLE   6
`define TP_P1_UPDOWN  5
`define TP_P1_HALT    4
`define TP_P1_IMM     3
`define TP_P1_ALL     2
`define TP_P1_DELAY_PRESCALE_SEL_HI 1
// PWM control two field.
`define TP_P2_FORCEA  7
// Status bit set on period match.
`define TP_ISR_PM     0
// Timer ticks that an immediate update needs to pass the synchroniser.
`define TP_SYNC_TICKS 2'd3
`endif

// ---- common/tp_pkg.sv ----
package tp_pkg;
  // Whole state of the timer pair, registered as one word.
  typedef struct packed {
    logic [7:0]       timer7_control;    // First timer control.
    logic [7:0]       timer7_compare_value;    // First timer compare value.
    logic [7:0]       timer7_count_value;   // First timer count.
    logic [7:0]       t7cap;   // First timer capture.
    logic             t7tog;   // Toggle output level.
    logic             t7hit;   // Match event, one cycle.
    logic             ec_q;    // Last external clock level.
    logic [14:0]      pre;     // Free running prescaler.
    logic [7:0]       timer8_control;    // Second timer control.
    logic [7:0]       pcr1;    // PWM control one.
    logic [7:0]       pcr2;    // PWM control two.
    logic [7:0]       pcr3;    // PWM control three.
    logic [7:0]       isr;     // Sticky status.
    logic [7:0]       msk;     // Status mask.
    logic [7:0]       timer8_compare_value;    // Second timer compare value.
    logic [7:0]       t8cap;   // Second timer capture.
    logic [9:0]       per_sh;  // Written period.
    logic [9:0]       per;     // Active period.
    logic [2:0][9:0]  dut_sh;  // Written duties.
    logic [2:0][9:0]  dut;     // Active duties.
    logic [2:0][7:0]  dly;     // Delay nibbles per channel.
    logic [9:0]       pc;      // PWM counter.
    logic             down;    // Counting down.
    logic [1:0]       pend;    // Immediate update countdown.
    logic [5:0][6:0]  dc;      // Delay counters, in PWM ticks.
    logic [5:0]       lvl;     // Delayed levels.
    logic [5:0]       pin;     // Gated pin levels.
    logic [31:0]      rdata;   // Read data.
    logic             err;     // Pending slave error.
  } tp_state_t;
endpackage

// ---- src/tp_timer_pwm.sv ----
// Contract
// - Buffered values load at period match only.
// - Immediate select applies new values without waiting for a match.
// - Immediate data passes three timer tick synchroniser.
// - Up/down mode alternates direction, period twice the period value.
// - Blanking low with sync clears counter, outputs.
// - Blanking high again restarts counter and waveform.
// - Halt clears counter and outputs, keeps settings.
// - Start/stop stop leaves outputs at level.
// - Force mode drives every pair from A.
// - Normal mode, each channel own duty, complementary.
// - Write-all copies A duty into B, C.
// - Four-bit delay of one edge per output.
// - Delay clock prescaled by one to eight.
// - Shared address reads count or capture.
// - Control has enable and interrupt enable bits.
// - Mode bit selects toggle timer or capture.
// - Clock select picks divider or external clock.
// - Continue bit low pauses, keeping count.
// - Start bit written low stops counter.
// - Start bit written high clears then counts.
`include "tp_consts.svh"
module tp_timer_pwm (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [15:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic        EXTERNAL_COUNT_CLOCK_I,
  input  wire logic        CAP7_I,
  input  wire logic        CAP8_I,
  input  wire logic        BLANKING_INPUT_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             FIRST_TIMER_TOGGLE_OUT_O,
  output logic             T7_MATCH_O,
  output logic [2:0]       PWM_OUT_TRUE_O,
  output logic [2:0]       PWM_OUT_INVERSE_O
);

  tp_pkg::tp_state_t r;       // Registered state.
  tp_pkg::tp_state_t n;       // Next state.
  logic [13:0]       idx;     // Word index of the access.
  logic              known;   // Address decodes to a register.
  logic              setup;   // APB setup cycle.
  logic              wr;      // APB write taken this cycle.
  logic [7:0]        wd;      // Written byte.
  logic [14:0]       m7;      // First timer tick mask.
  logic [14:0]       m8;      // Second timer tick mask.
  logic              tick7;   // First timer tick.
  logic              tick8;   // Second timer tick.
  logic [6:0]        dlim;    // Delay of the output in hand, in PWM ticks.
  logic              imm;     // Immediate update selected.
  logic              quiet;   // Outputs forced to reset value.
  logic              run8;    // PWM counter may advance.
  logic              pm;      // Period match this cycle.
  logic [2:0]        cmp;     // Duty comparisons.
  logic [5:0]        tgt;     // Undelayed output levels.
  logic [3:0]        dsel;    // Delay of the output in hand.
  logic              wsh;     // Write into a buffered register.

  // Decode of the APB access; the register bus never waits.
  assign idx     = PADDR_I[15:2];
  assign setup   = PSEL_I && !PENABLE_I;
  assign wr      = PSEL_I && PENABLE_I && PWRITE_I && known;
  assign wd      = PWDATA_I[7:0];
  assign known   = (PADDR_I[1:0] == 2'h0) &&
                   (idx >= `TP_IDX_TIMER7_CONTROL) && (idx <= `TP_IDX_TIMER8_COUNT_VALUE);
  assign imm     = r.pcr1[`TP_P1_IMM];

  // First timer divider masks: fx/2 up to fx/2048.
  always_comb begin
    unique case (r.timer7_control[`TP_T7_CK_HI:`TP_T7_CK_LO])
      3'h0:    m7 = 15'h0001;
      3'h1:    m7 = 15'h0003;
      3'h2:    m7 = 15'h0007;
      3'h3:    m7 = 15'h001f;
      3'h4:    m7 = 15'h007f;
      3'h5:    m7 = 15'h01ff;
      3'h6:    m7 = 15'h07ff;
      3'h7:    m7 = 15'h0000;
    endcase
  end

  // A tick fires when the masked prescaler bits are all ones.
  // Code seven counts rising edges of the external clock instead.
  assign tick7 = (r.timer7_control[`TP_T7_CK_HI:`TP_T7_CK_LO] == 3'h7) ?
                 (EXTERNAL_COUNT_CLOCK_I && !r.ec_q) :
                 ((r.pre & m7) == m7);

  // Second timer divides by two to the power of its code.
  // The chained code borrows the first timer's tick; software must
  // not use it while the timers run apart, so nothing guards it.
  assign m8    = 15'((16'h1 << r.timer8_control[`TP_T8_CK_HI:0]) - 16'h1);
  assign tick8 = (r.timer8_control[`TP_T8_CK_HI:0] == 4'hf) ? tick7 :
                 ((r.pre & m8) == m8);

  // Delay counters count PWM ticks up to the nibble times 1, 2, 4 or 8.
  // Counting whole PWM ticks keeps the delay exact; a shared divided
  // clock would make the first step short by an unknown phase.
  // The limit itself is worked out per output inside the state logic.

  // Halt, blanking or PWM off force the reset value.
  assign quiet = r.pcr1[`TP_P1_HALT] || !r.pcr1[`TP_P1_PWMEN] ||
                 (r.pcr1[`TP_P1_EXT_SYNC_ENABLE] && !BLANKING_INPUT_I);
  assign run8  = r.timer8_control[`TP_T8_ST] && r.timer8_control[`TP_T8_CN];

  // Comparisons; force mode takes every channel from A.
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      cmp[c] = r.pc < (r.pcr2[`TP_P2_FORCEA] ? r.dut[0] : r.dut[c]);
      tgt[2*c] = cmp[c] ^ r.pcr3[5-2*c];
      tgt[2*c+1] = (r.pcr2[`TP_P2_FORCEA] ? cmp[0] : !cmp[c]) ^
                   r.pcr3[4-2*c];
    end
  end

  // A write lands in a period or duty buffer.
  assign wsh = wr && (idx >= `TP_IDX_PERL) && (idx <= `TP_IDX_DCH);

  // Whole next state of the block.
  always_comb begin
    n     = r;
    pm    = 1'b0;
    dsel  = 4'h0;
    dlim  = 7'h0;
    n.t7hit = 1'b0;
    n.pre   = r.pre + 15'h1;
    n.ec_q  = EXTERNAL_COUNT_CLOCK_I;

    // First timer counts while enabled, started and continuing.
    if (r.timer7_control[`TP_T7_EN] && r.timer7_control[`TP_T7_ST] && r.timer7_control[`TP_T7_CN] &&
        tick7) begin
      if (r.timer7_count_value == r.timer7_compare_value) begin
        n.timer7_count_value = 8'h0;
        n.t7hit = r.timer7_control[`TP_T7_IE];
        // Toggle only in timer mode; capture mode still matches.
        if (!r.timer7_control[`TP_T7_MS]) begin
          n.t7tog = !r.t7tog;
        end
      end else begin
        n.timer7_count_value = r.timer7_count_value + 8'h1;
      end
    end

    // Capture strobes latch the running counts.
    if (CAP7_I && r.timer7_control[`TP_T7_MS]) begin
      n.t7cap = r.timer7_count_value;
    end
    if (CAP8_I && r.timer8_control[`TP_T8_MS]) begin
      n.t8cap = r.pc[7:0];
    end

    // PWM counter: cleared while quiet, else it steps on each tick while running.
    if (quiet) begin
      n.pc   = 10'h0;
      n.down = 1'b0;
    end else if (run8 && tick8) begin
      if (!r.down) begin
        if (r.pc >= r.per) begin
          pm = 1'b1;
          // Up/down mode turns round instead of wrapping.
          if (r.pcr1[`TP_P1_UPDOWN] && r.pc != 10'h0) begin
            n.pc   = r.pc - 10'h1;
            n.down = 1'b1;
          end else begin
            n.pc = 10'h0;
          end
        end else begin
          n.pc = r.pc + 10'h1;
        end
      end else if (r.pc == 10'h0) begin
        n.pc   = 10'h1;
        n.down = 1'b0;
      end else begin
        n.pc = r.pc - 10'h1;
      end
    end

    // Sticky period match status; the set beats a clear.
    if (pm) begin
      n.isr[`TP_ISR_PM] = 1'b1;
    end

    // Buffered values move over only at a period match.
    if (pm && !imm) begin
      n.per = r.per_sh;
      n.dut = r.dut_sh;
    end

    // Immediate values ride a three tick synchroniser first.
    if (r.pend != 2'h0 && tick8) begin
      n.pend = r.pend - 2'h1;
      if (r.pend == 2'h1) begin
        n.per = r.per_sh;
        n.dut = r.dut_sh;
      end
    end

    // Output delay: one edge waits, the other passes at once.
    for (int i = 0; i < 6; i++) begin
      dsel = i[0] ? r.dly[i>>1][3:0] : r.dly[i>>1][7:4];
      // Prescale by 1, 2, 4 or 8; at most 15 times 8 ticks.
      dlim = 7'(dsel) << r.pcr1[`TP_P1_DELAY_PRESCALE_SEL_HI:0];
      if (quiet) begin
        n.lvl[i] = 1'b0;
        n.dc[i]  = 7'h0;
      end else if (!run8) begin
        // A stopped counter leaves the pins where they were.
        n.lvl[i] = r.lvl[i];
      end else if (tgt[i] == r.lvl[i]) begin
        n.dc[i] = 7'h0;
      end else if (tgt[i] != r.pcr3[5-i] || dsel == 4'h0) begin
        n.lvl[i] = tgt[i];
        n.dc[i]  = 7'h0;
      end else if (tick8) begin
        // The delayed edge lands exactly dlim ticks late.
        if (r.dc[i] == dlim) begin
          n.lvl[i] = tgt[i];
          n.dc[i]  = 7'h0;
        end else begin
          n.dc[i] = r.dc[i] + 7'h1;
        end
      end
      n.pin[i] = n.lvl[i] && r.pcr2[5-i] && !quiet;
    end

    // Read data is fetched in the setup cycle and shown in the access.
    if (setup) begin
      n.err   = !known;
      n.rdata = 32'h0;
      unique case (idx)
        `TP_IDX_TIMER7_CONTROL:  n.rdata[7:0] = r.timer7_control;
        // Shared address: capture in capture mode, else the count.
        `TP_IDX_T7DAT: n.rdata[7:0] = r.timer7_control[`TP_T7_MS] ? r.t7cap : r.timer7_count_value;
        `TP_IDX_TIMER8_CONTROL:  n.rdata[7:0] = r.timer8_control;
        `TP_IDX_PCR1:  n.rdata[7:0] = r.pcr1;
        `TP_IDX_PCR2:  n.rdata[7:0] = r.pcr2;
        `TP_IDX_PCR3:  n.rdata[7:0] = r.pcr3;
        `TP_IDX_ISR:   n.rdata[7:0] = r.isr;
        `TP_IDX_MSK:   n.rdata[7:0] = r.msk;
        `TP_IDX_PERL:  n.rdata[7:0] = r.per_sh[7:0];
        `TP_IDX_PERH:  n.rdata[1:0] = r.per_sh[9:8];
        `TP_IDX_DAL:   n.rdata[7:0] = r.dut_sh[0][7:0];
        `TP_IDX_DAH:   n.rdata[1:0] = r.dut_sh[0][9:8];
        `TP_IDX_DBL:   n.rdata[7:0] = r.dut_sh[1][7:0];
        `TP_IDX_DBH:   n.rdata[1:0] = r.dut_sh[1][9:8];
        `TP_IDX_DCL:   n.rdata[7:0] = r.dut_sh[2][7:0];
        `TP_IDX_DCH:   n.rdata[1:0] = r.dut_sh[2][9:8];
        `TP_IDX_DLYA:  n.rdata[7:0] = r.dly[0];
        `TP_IDX_DLYB:  n.rdata[7:0] = r.dly[1];
        `TP_IDX_DLYC:  n.rdata[7:0] = r.dly[2];
        `TP_IDX_TIMER8_COMPARE_VALUE:  n.rdata[7:0] = r.timer8_compare_value;
        `TP_IDX_T8CAP: n.rdata[7:0] = r.t8cap;
        `TP_IDX_TIMER8_COUNT_VALUE: n.rdata[7:0] = r.pc[7:0];
        default:       n.rdata = 32'h0;
      endcase
    end

    // Register writes come last so that they win over counting.
    if (wr) begin
      unique case (idx)
        `TP_IDX_TIMER7_CONTROL: begin
          n.timer7_control = wd;
          // Writing start high clears the count first.
          if (wd[`TP_T7_ST]) begin
            n.timer7_count_value = 8'h0;
          end
        end
        // Writes to the shared address always load the compare.
        `TP_IDX_T7DAT: n.timer7_compare_value = wd;
        `TP_IDX_TIMER8_CONTROL: begin
          n.timer8_control = wd;
          if (wd[`TP_T8_ST]) begin
            n.pc   = 10'h0;
            n.down = 1'b0;
          end
        end
        `TP_IDX_PCR1:  n.pcr1 = wd;
        `TP_IDX_PCR2:  n.pcr2 = {wd[7], 1'b0, wd[5:0]};
        `TP_IDX_PCR3:  n.pcr3 = wd;
        // Status bits clear by writing one, unless set this cycle.
        `TP_IDX_ISR:   n.isr = (r.isr & ~wd) | {7'h0, pm};
        `TP_IDX_MSK:   n.msk = wd;
        `TP_IDX_PERL:  n.per_sh[7:0] = wd;
        `TP_IDX_PERH:  n.per_sh[9:8] = wd[1:0];
        `TP_IDX_DAL: begin
          n.dut_sh[0][7:0] = wd;
          // Write-all copies the A duty byte into B and C.
          if (r.pcr1[`TP_P1_ALL]) begin
            n.dut_sh[1][7:0] = wd;
            n.dut_sh[2][7:0] = wd;
          end
        end
        `TP_IDX_DAH: begin
          n.dut_sh[0][9:8] = wd[1:0];
          if (r.pcr1[`TP_P1_ALL]) begin
            n.dut_sh[1][9:8] = wd[1:0];
            n.dut_sh[2][9:8] = wd[1:0];
          end
        end
        `TP_IDX_DBL:   n.dut_sh[1][7:0] = wd;
        `TP_IDX_DBH:   n.dut_sh[1][9:8] = wd[1:0];
        `TP_IDX_DCL:   n.dut_sh[2][7:0] = wd;
        `TP_IDX_DCH:   n.dut_sh[2][9:8] = wd[1:0];
        `TP_IDX_DLYA:  n.dly[0] = wd;
        `TP_IDX_DLYB:  n.dly[1] = wd;
        `TP_IDX_DLYC:  n.dly[2] = wd;
        `TP_IDX_TIMER8_COMPARE_VALUE:  n.timer8_compare_value = wd;
        default:       n.err = 1'b0;
      endcase
      // An immediate write restarts the synchroniser countdown.
      if (wsh && imm) begin
        n.pend = `TP_SYNC_TICKS;
      end
    end

    // Synchronous reset to constants.
    if (RST_I) begin
      n                 = '0;
      n.timer7_compare_value            = `TP_RST_TIMER7_COMPARE_VALUE;
      n.timer8_compare_value            = `TP_RST_TIMER8_COMPARE_VALUE;
      n.per_sh          = `TP_RST_PER;
      n.per             = `TP_RST_PER;
      n.dut_sh          = {3{`TP_RST_DUTY}};
      n.dut             = {3{`TP_RST_DUTY}};
    end
  end

  // One register holds the whole state.
  always_ff @(posedge CLK_SYS_I) begin
    r <= n;
  end

  // Ports are driven straight from the state, except PREADY_O, which is tied high, and PSLVERR_O, which is gated by PSEL_I and PENABLE_I.
  assign PRDATA_O                 = r.rdata;
  assign PREADY_O                 = 1'b1;
  assign PSLVERR_O                = PSEL_I && PENABLE_I && r.err;
  assign FIRST_TIMER_TOGGLE_OUT_O = r.t7tog;
  assign T7_MATCH_O               = r.t7hit;
  assign PWM_OUT_TRUE_O           = {r.pin[4], r.pin[2], r.pin[0]};
  assign PWM_OUT_INVERSE_O        = {r.pin[5], r.pin[3], r.pin[1]};

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);

  // The active period never changes outside a match or the synchroniser.
  AST_BUFFERED: assert property (
    (r.per != $past(r.per)) && $past(r.pend) == 2'h0 |-> $past(pm))
    else $error("period loaded outside a period match");

  // The synchroniser lands the written period on its third tick.
  AST_SYNC: assert property (
    r.pend == 2'h1 && tick8 && !wr |=> r.per == $past(r.per_sh))
    else $error("immediate period not applied");

  // Halt clears counter and pins on the next edge and holds them.
  AST_HALT: assert property (
    r.pcr1[`TP_P1_HALT] && !wr |=> r.pc == 10'h0 && r.pin == 6'h0)
    else $error("halt did not clear counter and outputs");

  // Blanking low with sync enabled clears the counter.
  AST_BLANK: assert property (
    r.pcr1[`TP_P1_EXT_SYNC_ENABLE] && !BLANKING_INPUT_I |=> r.pc == 10'h0)
    else $error("blanking did not clear counter");

  // Down counting steps by exactly one.
  AST_DOWN: assert property (
    !quiet && run8 && tick8 && r.down && r.pc != 10'h0 && !wr
    |=> r.pc == $past(r.pc) - 10'h1)
    else $error("down count step wrong");

  // Stopped counter keeps every pin level.
  AST_HOLD: assert property (
    !quiet && !run8 && !wr ##1 !quiet |-> $stable(r.lvl))
    else $error("outputs moved while stopped");

  // Write-all duty lands in the B and C buffers too.
  AST_ALL: assert property (
    wr && idx == `TP_IDX_DAL && r.pcr1[`TP_P1_ALL]
    |=> r.dut_sh[1][7:0] == $past(wd) && r.dut_sh[2][7:0] == $past(wd))
    else $error("write-all did not reach B and C");

  // Starting the first timer clears its count.
  AST_START: assert property (
    wr && idx == `TP_IDX_TIMER7_CONTROL && wd[`TP_T7_ST] |=> r.timer7_count_value == 8'h0)
    else $error("start did not clear the count");

  // Pause keeps the count for two cycles at least.
  AST_PAUSE: assert property (
    (!r.timer7_control[`TP_T7_CN] && !wr) [*2] |=> $stable(r.timer7_count_value))
    else $error("count moved while paused");

  // Zero delay means the level follows the target one edge later.
  AST_NODELAY: assert property (
    !quiet && run8 && r.dly[0][7:4] == 4'h0 && !wr |=> r.lvl[0] == $past(tgt[0]))
    else $error("zero delay still delayed");

endmodule

// ---- dv/tp_gate_model.sv ----
module tp_gate_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       blank_req_i,
  input  wire logic [2:0] hi_i,
  input  wire logic [2:0] lo_i,
  output logic            blank_n_o,
  output int              overlap_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // The stage pulls its fault line high; a fault request pulls it low.
  assign blank_n_o = !blank_req_i;

  // Both switches of one leg on together would short the supply, so count it.
  always @(posedge clk_i) begin
    if (rst_i) begin
      overlap_o <= 0;
    end else if (|(hi_i & lo_i)) begin
      overlap_o <= overlap_o + 1;
    end
  end
endmodule

// ---- dv/test_timer_pair_three_phase_pwm.sv ----
`include "tp_consts.svh"
module test_timer_pair_three_phase_pwm;
  timeunit 1ns;
  timeprecision 1ps;

  // One expected read: data, error flag, and whether the data is ignored.
  typedef struct packed {
    logic [31:0] data;
    logic        err;
    logic        any;
  } tp_note_t;

  logic        clk_sys, rst, psel, penable, pwrite, ext_clk, blank_req, blank_n;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, tog, match, sel, probe;
  logic [2:0]  hi, lo;
  int          miscompares, compares, seed, overlap;
  tp_note_t    note_q[$];
  tp_note_t    note;

  // Measurements follow either the toggle output or the true A pin.
  assign probe = sel ? tog : hi[0];

  tp_timer_pwm dut (
    .CLK_SYS_I(clk_sys), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .EXTERNAL_COUNT_CLOCK_I(ext_clk), .CAP7_I(1'b0), .CAP8_I(1'b0),
    .BLANKING_INPUT_I(blank_n), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .FIRST_TIMER_TOGGLE_OUT_O(tog), .T7_MATCH_O(match),
    .PWM_OUT_TRUE_O(hi), .PWM_OUT_INVERSE_O(lo));

  tp_gate_model gate (
    .clk_i(clk_sys), .rst_i(rst), .blank_req_i(blank_req), .hi_i(hi), .lo_i(lo),
    .blank_n_o(blank_n), .overlap_o(overlap));

  // Free running system clock.
  always #2 clk_sys = ~clk_sys;

  // The external count input wanders at random; the test never selects it as the first timer clock.
  always @(posedge clk_sys) begin
    ext_clk <= $random(seed);
  end

  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %0h want %0h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic [13:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= {idx, 2'b00};
    pwrite <= wr;
    pwdata <= {24'h000000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // A read notes its expectation first; the monitor judges the answer.
  task automatic rd(input logic [13:0] idx, input logic [7:0] exp, input logic err);
    note_q.push_back('{{24'h000000, exp}, err, err});
    apb(idx, 1'b0, 8'h00);
  endtask

  // Monitor: each completed read takes the oldest note off the queue.
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (note_q.size() == 0) begin
        miscompares++;
        $display("MISMATCH %0t read without expectation", $time);
      end else begin
        note = note_q.pop_front();
        compares++;
        if (pslverr !== note.err || (!note.any && prdata !== note.data)) begin
          miscompares++;
          $display("MISMATCH %0t read %0h err %b", $time, prdata, pslverr);
        end
      end
    end
  end

  // High time and full period of the probe, checking the inverse A pin at both edges when probing the true A pin.
  task automatic measure(output int h, output int p);
    int i;
    h = 0;
    for (i = 0; i < 300 && probe !== 1'b0; i++) @(negedge clk_sys);
    for (i = 0; i < 300 && probe !== 1'b1; i++) @(negedge clk_sys);
    if (!sel) chk(lo[0], 1'b0);
    while (probe === 1'b1 && h < 300) begin
      @(negedge clk_sys);
      h++;
    end
    p = h;
    if (!sel) chk(lo[0], 1'b1);
    while (probe === 1'b0 && p < 600) begin
      @(negedge clk_sys);
      p++;
    end
  endtask

  // Pins must sit at their reset level and the counter at zero.
  task automatic held;
    repeat (3) @(negedge clk_sys);
    repeat (20) begin
      @(negedge clk_sys);
      chk({hi, lo}, 6'h00);
    end
    rd(`TP_IDX_TIMER8_COUNT_VALUE, 8'h00, 1'b0);
  endtask

  // Watchdog: the whole run needs far less than this.
  initial begin
    #200000;
    miscompares++;
    summarize();
  end

  initial begin
    int base, h, p, p0, ov;
    logic [5:0] save;
    logic [7:0] duty;
    seed = 89144;
    clk_sys = 1'b0;
    {rst, psel, penable, pwrite, ext_clk, blank_req, sel} = 7'b1000000;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`TP_IDX_TIMER7_CONTROL, 8'h00, 1'b0);
    rd(`TP_IDX_T7DAT, 8'h00, 1'b0);
    rd(`TP_IDX_PERL, 8'hff, 1'b0);
    rd(`TP_IDX_DAL, 8'h7f, 1'b0);
    rd(`TP_IDX_TIMER8_COMPARE_VALUE, 8'hff, 1'b0);
    rd(14'h1066, 8'h00, 1'b1);
    duty = 8'h04 + ($random(seed) & 8'h07);
    apb(`TP_IDX_PCR2, 1'b1, 8'h3f);
    apb(`TP_IDX_PCR1, 1'b1, 8'h88);
    apb(`TP_IDX_PERL, 1'b1, 8'h0f);
    apb(`TP_IDX_PERH, 1'b1, 8'h00);
    apb(`TP_IDX_DAL, 1'b1, duty);
    apb(`TP_IDX_DAH, 1'b1, 8'h00);
    apb(`TP_IDX_TIMER8_CONTROL, 1'b1, 8'h30);
    repeat (8) @(posedge clk_sys);
    measure(base, p);
    chk(p, 16);
    chk(overlap, 0);
    apb(`TP_IDX_DLYA, 1'b1, 8'h20);
    measure(h, p);
    chk(h, base + 2);
    apb(`TP_IDX_PCR1, 1'b1, 8'h89);
    measure(h, p);
    chk(h, base + 4);
    apb(`TP_IDX_DLYA, 1'b1, 8'h00);
    apb(`TP_IDX_PCR1, 1'b1, 8'ha8);
    measure(h, p);
    ov = overlap;
    measure(h, p);
    chk(p, 30);
    apb(`TP_IDX_PCR1, 1'b1, 8'h98);
    held();
    apb(`TP_IDX_PCR1, 1'b1, 8'h88);
    measure(h, p);
    chk(p, 16);
    apb(`TP_IDX_PCR1, 1'b1, 8'hc8);
    blank_req <= 1'b1;
    held();
    blank_req <= 1'b0;
    measure(h, p);
    chk(p, 16);
    apb(`TP_IDX_TIMER8_CONTROL, 1'b1, 8'h20);
    repeat (2) @(negedge clk_sys);
    save = {hi, lo};
    repeat (20) begin
      @(negedge clk_sys);
      chk({hi, lo}, save);
    end
    sel = 1'b1;
    apb(`TP_IDX_T7DAT, 1'b1, 8'h05);
    apb(`TP_IDX_TIMER7_CONTROL, 1'b1, 8'h83);
    measure(h, p0);
    measure(h, p0);
    apb(`TP_IDX_TIMER7_CONTROL, 1'b1, 8'h87);
    measure(h, p);
    measure(h, p);
    chk(p, 2 * p0);
    apb(`TP_IDX_TIMER7_CONTROL, 1'b1, 8'hc7);
    while (match !== 1'b1) @(negedge clk_sys);
    h = 0;
    repeat (192) begin
      @(negedge clk_sys);
      if (match === 1'b1) h++;
    end
    chk(h, 8);
    apb(`TP_IDX_PCR1, 1'b1, 8'h8c);
    apb(`TP_IDX_DAL, 1'b1, 8'h30);
    rd(`TP_IDX_DBL, 8'h30, 1'b0);
    rd(`TP_IDX_DCL, 8'h30, 1'b0);
    repeat (4) @(posedge clk_sys);
    chk(overlap, ov);
    summarize();
  end
endmodule
